// ---- verilog/ogtb_top.sv ----
// Purpose: offset and fine-gain trim bank for a two-core converter
// Assumes: apb slave on sys_clk; fuse words and sample select same clock
// Notes:   one wait-free access phase; trims applied only under fg cal
//
// Behaviour
// - the b core offset field (bits 11:0 at 0x34e) is applied when that core samples input b under foreground calibration.
// - the same b core input b offset serves dual and single mode alike.
// - dual mode gains sit in bits 4:0 at 0x350..0x353 for a0, a1, b0, b1.
// - single mode gains sit at 0x354..0x357 for a0, a1, b0, b1.
// - offset and gain fields are loaded from fuse storage after reset.
// - upper bits are reserved read-write bits that reset to zero.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module ogtb_top #(
  parameter int ADDR_W = 14
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   b_samples_input_b,
  input  wire logic [ogtb_pkg::OFFS_W-1:0] fuse_offset,
  input  wire logic [ogtb_pkg::NUM_GAIN*ogtb_pkg::GAIN_W-1:0] fuse_gain,
  output logic [ogtb_pkg::OFFS_W-1:0] b_input_b_offset,
  output logic [ogtb_pkg::GAIN_W-1:0] gain_a_bank0,
  output logic [ogtb_pkg::GAIN_W-1:0] gain_a_bank1,
  output logic [ogtb_pkg::GAIN_W-1:0] gain_b_bank0,
  output logic [ogtb_pkg::GAIN_W-1:0] gain_b_bank1,
  output logic                        fg_cal_active,
  output logic                        single_mode_active
);
  import ogtb_pkg::*;

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  if (ADDR_W < IDX_W + 2) begin : g_addr_check
    $error("ADDR_W too small for the register indices");
  end

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  // byte lane merge for one 8-bit lane
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       strb);
    lane_merge = strb ? new_v : old_v;
  endfunction : lane_merge

  // word index to slot code
  function automatic logic [3:0] slot_of(input logic [IDX_W-1:0] idx);
    unique case (idx)
      IDX_DUAL_A_BANK0:   slot_of = 4'h0;
      IDX_DUAL_A_BANK1:   slot_of = 4'h1;
      IDX_DUAL_B_BANK0:   slot_of = 4'h2;
      IDX_DUAL_B_BANK1:   slot_of = 4'h3;
      IDX_SINGLE_A_BANK0: slot_of = 4'h4;
      IDX_SINGLE_A_BANK1: slot_of = 4'h5;
      IDX_SINGLE_B_BANK0: slot_of = 4'h6;
      IDX_SINGLE_B_BANK1: slot_of = 4'h7;
      IDX_OFFSET_B_VINB:  slot_of = SLOT_OFFSET;
      IDX_CTRL:           slot_of = SLOT_CTRL;
      IDX_STATUS:         slot_of = SLOT_STATUS;
      default:            slot_of = SLOT_NONE;
    endcase
  endfunction : slot_of

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [OFFS_REG_W-1:0] offset_q;
  logic [GAIN_REG_W-1:0] gain_q [NUM_GAIN];
  logic [1:0]            ctrl_q;
  logic                  load_pend_q;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire logic [ADDR_W-1:0] word_idx = paddr >> 2;
  wire logic              hi_ok    = (word_idx >> IDX_W) == '0;
  wire logic              align_ok = paddr[1:0] == 2'h0;
  wire logic [3:0]        slot     = (hi_ok && align_ok)
                                   ? slot_of(word_idx[IDX_W-1:0])
                                   : SLOT_NONE;
  wire logic              setup    = psel & ~penable;
  wire logic              access   = psel & penable & pready;
  wire logic              wr_en    = ce & access & pwrite;
  wire logic              is_gain  = ~slot[3];
  wire logic [2:0]        gidx     = slot[2:0];
  wire logic              bad      = slot == SLOT_NONE;
  wire logic              fg_en    = ctrl_q[CTRL_FG_BIT];
  wire logic              single   = ctrl_q[CTRL_SGL_BIT];

  // status word shows live block state
  wire logic [31:0] status_word = {29'h0, fg_en, single, ~load_pend_q};

  // read selection
  wire logic [31:0] rd_word =
      is_gain              ? {24'h0, gain_q[gidx]} :
      slot == SLOT_OFFSET  ? {16'h0, offset_q} :
      slot == SLOT_CTRL    ? {30'h0, ctrl_q} :
      slot == SLOT_STATUS  ? status_word : 32'h0;

  // ------------------------------------------------------------------
  // gain set selection by channel mode
  // ------------------------------------------------------------------
  wire logic [2:0] set_base = single ? SINGLE_BASE : 3'h0;
  wire logic [GAIN_W-1:0] sel_a0 = gain_q[set_base][GAIN_W-1:0];
  wire logic [GAIN_W-1:0] sel_a1 = gain_q[set_base + 3'h1][GAIN_W-1:0];
  wire logic [GAIN_W-1:0] sel_b0 = gain_q[set_base + 3'h2][GAIN_W-1:0];
  wire logic [GAIN_W-1:0] sel_b1 = gain_q[set_base + 3'h3][GAIN_W-1:0];

  // ------------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------------
  // ready and data one cycle after setup, error for unmapped words
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= setup;
      prdata  <= (setup && !pwrite && !bad) ? rd_word : 32'h0;
      pslverr <= setup & bad;
    end
  end

  // ------------------------------------------------------------------
  // offset register
  // ------------------------------------------------------------------
  // fuse load first, then software writes per byte lane
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      offset_q <= RST_OFFSET;
    end else if (ce && load_pend_q) begin
      offset_q[OFFS_W-1:0] <= fuse_offset;
    end else if (wr_en && slot == SLOT_OFFSET) begin
      offset_q[7:0]  <= lane_merge(offset_q[7:0], pwdata[7:0], pstrb[0]);
      offset_q[15:8] <= lane_merge(offset_q[15:8], pwdata[15:8],
                                   pstrb[1]);
    end
  end

  // ------------------------------------------------------------------
  // gain registers
  // ------------------------------------------------------------------
  // eight trims: dual set at 0..3, single set at 4..7
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int k = 0; k < NUM_GAIN; k++) begin
        gain_q[k] <= RST_GAIN;
      end
    end else if (ce && load_pend_q) begin
      for (int k = 0; k < NUM_GAIN; k++) begin
        gain_q[k][GAIN_W-1:0] <= fuse_gain[k*GAIN_W +: GAIN_W];
      end
    end else if (wr_en && is_gain) begin
      gain_q[gidx] <= lane_merge(gain_q[gidx], pwdata[7:0],
                                 pstrb[0]);
    end
  end

  // ------------------------------------------------------------------
  // control and fuse load flag
  // ------------------------------------------------------------------
  // load flag clears on the first enabled cycle after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q      <= RST_CTRL;
      load_pend_q <= 1'b1;
    end else if (ce) begin
      load_pend_q <= 1'b0;
      if (wr_en && slot == SLOT_CTRL && pstrb[0]) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // trims applied to the converter cores
  // ------------------------------------------------------------------
  // zero trim unless foreground calibration is on
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      b_input_b_offset   <= '0;
      gain_a_bank0       <= '0;
      gain_a_bank1       <= '0;
      gain_b_bank0       <= '0;
      gain_b_bank1       <= '0;
      fg_cal_active      <= 1'b0;
      single_mode_active <= 1'b0;
    end else if (ce) begin
      b_input_b_offset   <= (fg_en && b_samples_input_b)
                            ? offset_q[OFFS_W-1:0] : '0;
      gain_a_bank0       <= fg_en ? sel_a0 : '0;
      gain_a_bank1       <= fg_en ? sel_a1 : '0;
      gain_b_bank0       <= fg_en ? sel_b0 : '0;
      gain_b_bank1       <= fg_en ? sel_b1 : '0;
      fg_cal_active      <= fg_en;
      single_mode_active <= single;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_b_sample;
    ce && fg_en && b_samples_input_b;
  endsequence

  sequence s_setup_ok;
    ce && setup && !bad;
  endsequence

  AST_OFFSET_APPLIED: assert property (
    s_b_sample |=> b_input_b_offset == $past(offset_q[OFFS_W-1:0])
  ) else $error("b input b offset not applied");

  AST_OFFSET_BOTH_MODES: assert property (
    (s_b_sample ##1 (ce && fg_en && b_samples_input_b
                     && $changed(single) && $stable(offset_q)))
    |=> $stable(b_input_b_offset)
  ) else $error("offset changed with channel mode");

  AST_DUAL_SET: assert property (
    (ce && fg_en && !single) |=>
      gain_a_bank0 == $past(gain_q[0][GAIN_W-1:0]) &&
      gain_a_bank1 == $past(gain_q[1][GAIN_W-1:0]) &&
      gain_b_bank0 == $past(gain_q[2][GAIN_W-1:0]) &&
      gain_b_bank1 == $past(gain_q[3][GAIN_W-1:0])
  ) else $error("dual gain set misrouted");

  AST_SINGLE_SET: assert property (
    (ce && fg_en && single) |=>
      gain_a_bank0 == $past(gain_q[4][GAIN_W-1:0]) &&
      gain_a_bank1 == $past(gain_q[5][GAIN_W-1:0]) &&
      gain_b_bank0 == $past(gain_q[6][GAIN_W-1:0]) &&
      gain_b_bank1 == $past(gain_q[7][GAIN_W-1:0])
  ) else $error("single gain set misrouted");

  AST_FUSE_LOAD: assert property (
    (ce && load_pend_q) |=>
      !load_pend_q &&
      offset_q[OFFS_W-1:0] == $past(fuse_offset) &&
      gain_q[7][GAIN_W-1:0] == $past(fuse_gain[7*GAIN_W +: GAIN_W])
  ) else $error("fuse defaults not loaded");

  AST_RESERVED_RESET: assert property (
    load_pend_q |-> offset_q[15:12] == 4'h0 && gain_q[0][7:5] == 3'h0
  ) else $error("reserved bits not zero after reset");

  AST_RESERVED_RW: assert property (
    (wr_en && slot == SLOT_OFFSET && pstrb[1] && !load_pend_q) |=>
      offset_q[15:12] == $past(pwdata[15:12])
  ) else $error("reserved offset bits not writable");

  AST_GAIN_OFF: assert property (
    (ce && !fg_en) |=> gain_a_bank0 == '0 && gain_b_bank1 == '0
                       && b_input_b_offset == '0
  ) else $error("trim applied without foreground calibration");

  AST_APB_ANSWER: assert property (
    (s_setup_ok and (!pwrite)) |=> pready && !pslverr
                                   && prdata == $past(rd_word)
  ) else $error("read answer not one cycle after setup");

  // refused access: error with ready, no data
  sequence s_bad_setup;
    ce && setup && bad;
  endsequence

  AST_UNMAPPED_ERR: assert property (
    s_bad_setup |=> pready && pslverr && prdata == 32'h0
  ) else $error("unmapped access not refused");

  AST_GAIN_WR_DUAL: assert property (
    (wr_en && slot == 4'h0 && pstrb[0] && !load_pend_q) |=>
      gain_q[0] == $past(pwdata[7:0])
  ) else $error("dual gain write lost");

  AST_GAIN_WR_SINGLE: assert property (
    (wr_en && slot == 4'h7 && pstrb[0] && !load_pend_q) |=>
      gain_q[7] == $past(pwdata[7:0])
  ) else $error("single gain write lost");

  AST_CE_FREEZE: assert property (
    !ce |=> $stable(pready) && $stable(b_input_b_offset)
            && $stable(gain_a_bank0) && $stable(fg_cal_active)
  ) else $error("state moved while clock enable low");

  AST_MODE_COPY: assert property (
    ce |=> single_mode_active == $past(single)
           && fg_cal_active == $past(fg_en)
  ) else $error("channel mode not reported");

endmodule : ogtb_top

// ---- verilog/ogtb_pkg.sv ----
// Purpose: shared constants for the offset and gain trim bank
// Assumes: register indices are word indices; byte address is index * 4
// Notes:   one named constant per offset, field, reset value and bit
package ogtb_pkg;

  // ------------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------------
  localparam int          IDX_W              = 12;
  localparam logic [11:0] IDX_OFFSET_B_VINB  = 12'h34e;
  localparam logic [11:0] IDX_DUAL_A_BANK0   = 12'h350;
  localparam logic [11:0] IDX_DUAL_A_BANK1   = 12'h351;
  localparam logic [11:0] IDX_DUAL_B_BANK0   = 12'h352;
  localparam logic [11:0] IDX_DUAL_B_BANK1   = 12'h353;
  localparam logic [11:0] IDX_SINGLE_A_BANK0 = 12'h354;
  localparam logic [11:0] IDX_SINGLE_A_BANK1 = 12'h355;
  localparam logic [11:0] IDX_SINGLE_B_BANK0 = 12'h356;
  localparam logic [11:0] IDX_SINGLE_B_BANK1 = 12'h357;
  localparam logic [11:0] IDX_CTRL           = 12'h360;
  localparam logic [11:0] IDX_STATUS         = 12'h361;

  // ------------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------------
  localparam int          OFFS_W       = 12;
  localparam int          OFFS_REG_W   = 16;
  localparam int          GAIN_W       = 5;
  localparam int          GAIN_REG_W   = 8;
  localparam int          NUM_GAIN     = 8;
  localparam logic [2:0]  SINGLE_BASE  = 3'h4;
  localparam logic [15:0] RST_OFFSET   = 16'h0000;
  localparam logic [7:0]  RST_GAIN     = 8'h00;
  localparam logic [1:0]  RST_CTRL     = 2'h0;
  localparam int          CTRL_FG_BIT  = 0;
  localparam int          CTRL_SGL_BIT = 1;
  localparam int          STAT_LD_BIT  = 0;
  localparam int          STAT_SGL_BIT = 1;
  localparam int          STAT_FG_BIT  = 2;

  // ------------------------------------------------------------------
  // decoded slot codes
  // ------------------------------------------------------------------
  localparam logic [3:0]  SLOT_OFFSET  = 4'h8;
  localparam logic [3:0]  SLOT_CTRL    = 4'h9;
  localparam logic [3:0]  SLOT_STATUS  = 4'ha;
  localparam logic [3:0]  SLOT_NONE    = 4'hf;

endpackage : ogtb_pkg

// ---- verif/ogtb_tb_top.sv ----
// Purpose: self-checking bench for the offset and gain trim bank
// Assumes: ce high except in the freeze scenario; master waits for pready
// Notes:   integer model of the registers is compared at every result
`timescale 1ns/1ps
module tb_top;
  import ogtb_pkg::*;

  // ------------------------------------------------------------------
  // signals and model state
  // ------------------------------------------------------------------
  logic        sys_clk, rstn, ce, psel, penable, pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, err, b_samples_input_b;
  logic [11:0] fuse_offset, b_input_b_offset;
  logic [39:0] fuse_gain;
  logic [4:0]  gain_a_bank0, gain_a_bank1, gain_b_bank0, gain_b_bank1;
  logic        fg_cal_active, single_mode_active;
  int          failures, cmp_count, k, mode;
  int          m_reg[10];

  `define OGTB_CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin \
    failures++; $display("mismatch at %0t got %h expected %h", \
    $time, act, exp); end end

  ogtb_top #(.ADDR_W(14)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .b_samples_input_b(b_samples_input_b), .fuse_offset(fuse_offset),
    .fuse_gain(fuse_gain), .b_input_b_offset(b_input_b_offset),
    .gain_a_bank0(gain_a_bank0), .gain_a_bank1(gain_a_bank1),
    .gain_b_bank0(gain_b_bank0), .gain_b_bank1(gain_b_bank1),
    .fg_cal_active(fg_cal_active), .single_mode_active(single_mode_active)
  );

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic conclude();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // slot 0..7 gains, 8 offset, 9 control
  function automatic logic [13:0] addr_of(input int s);
    if (s == 8) return {IDX_OFFSET_B_VINB, 2'b00};
    if (s == 9) return {IDX_CTRL, 2'b00};
    return {IDX_DUAL_A_BANK0 + 12'(s), 2'b00};
  endfunction : addr_of

  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready, data and error are all taken at the same rising edge
    for (n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      `OGTB_CHK(pready, 1'b1)
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // write with model update per byte lane
  task automatic wr_reg(input int s, input logic [31:0] d,
                        input logic [3:0] b);
    apb(1'b1, addr_of(s), d, b);
    `OGTB_CHK(err, 1'b0)
    if (s == 9) begin
      if (b[0]) m_reg[9] = int'(d[1:0]);
    end else begin
      if (b[0]) m_reg[s][7:0] = d[7:0];
      if (s == 8 && b[1]) m_reg[s][15:8] = d[15:8];
    end
  endtask : wr_reg

  task automatic rd_reg(input int s);
    apb(1'b0, addr_of(s), 32'h0, 4'h0);
    `OGTB_CHK({err, rd}, {1'b0, m_reg[s]})
  endtask : rd_reg

  // reset with fresh fuse defaults loaded into the model
  task automatic do_reset();
    int j;
    rstn <= 1'b0;
    fuse_offset <= 12'($urandom);
    fuse_gain <= {8'($urandom), 32'($urandom)};
    repeat (4) @(posedge sys_clk);
    for (j = 0; j < 8; j++) m_reg[j] = int'(fuse_gain[5*j+:5]);
    m_reg[8] = int'(fuse_offset);
    m_reg[9] = 0;
    rstn <= 1'b1;
  endtask : do_reset

  // trim outputs against the selected set
  task automatic check_outs();
    logic [19:0] eg;
    logic [11:0] eo;
    int j;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    eg = '0;
    for (j = 0; j < 4; j++)
      if (m_reg[9][0]) eg[5*j+:5] = m_reg[(m_reg[9][1] ? 4 : 0) + j][4:0];
    eo = (m_reg[9][0] && b_samples_input_b) ? m_reg[8][11:0] : 12'h000;
    `OGTB_CHK({gain_b_bank1, gain_b_bank0, gain_a_bank1, gain_a_bank0}, eg)
    `OGTB_CHK(b_input_b_offset, eo)
    `OGTB_CHK({single_mode_active, fg_cal_active}, m_reg[9][1:0])
  endtask : check_outs

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0; rstn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0; pstrb = '0;
    b_samples_input_b = 1'b0; fuse_offset = '0; fuse_gain = '0;
    failures = 0; cmp_count = 0;
    void'($urandom(34));
    do_reset();
    for (k = 0; k < 10; k++) rd_reg(k);
    for (k = 0; k < 9; k++) wr_reg(k, $urandom, 4'hf);
    wr_reg(8, $urandom, 4'h2);
    for (k = 0; k < 10; k++) rd_reg(k);
    // every mode, fg and sampling combination
    for (mode = 0; mode < 8; mode++) begin
      wr_reg(9, 32'(mode), 4'h1);
      b_samples_input_b <= mode[2];
      check_outs();
      apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, 4'h0);
      `OGTB_CHK(rd, {29'h0, m_reg[9][0], m_reg[9][1], 1'b1})
    end
    // mode change while b keeps sampling input b under fg cal
    wr_reg(9, 32'h1, 4'h1);
    check_outs();
    // clock enable low freezes the applied trims
    @(posedge sys_clk);
    ce <= 1'b0;
    b_samples_input_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `OGTB_CHK(b_input_b_offset, m_reg[8][11:0])
    ce <= 1'b1;
    check_outs();
    // unmapped and misaligned places are refused
    apb(1'b0, 14'h0004, 32'h0, 4'h0);
    `OGTB_CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 14'hd3a, 32'hffff, 4'hf);
    `OGTB_CHK(err, 1'b1)
    rd_reg(8);
    // second reset in mid-run reloads the fuse defaults
    do_reset();
    for (k = 0; k < 10; k++) rd_reg(k);
    conclude();
  end
endmodule : tb_top
